// ==== verilog/swl_dev_end.sv ====
// Sensor end: angle frame output, programming slave and command mode.
// Notes on behaviour
// - After start-up, send angle frames continuously.
// - Entry needs long high guard, then sequence.
// - Master overpowers the active sensor driver.
// - Sensor end only answers, never initiates.
// - Every transaction opens with rise after low.
// - Command byte follows the start directly.
// - Write data words follow the command immediately.
// - Reads carry handover bits around the data.
// - Every transaction closes with a stop rise.
// - Long silence drops link back to idle.
// - Master resynchronises by staying silent long.
// - Entry is write 94h plus signature.
// - Command mode holds until power-on reset.
// - Command mode opens memory and registers.
// - Long high pulse is one, short zero.
// - Start low and stop high have minimums.
// - Master rewrites checksum after memory changes.
// - Command byte: region, address, read flag.
// - Bit period between 10 and 100 us.
// - After handover fall, sensor takes line low.
// - Entry accepted only 20 to 30 ms.
`timescale 1ns/100ps
`default_nettype none
module swl_dev_end
	import swl_pkg::*;
#(
	parameter int TO_CYC     = TIMEOUT_CYC,
	parameter int ON_CYC     = STARTUP_CYC,
	parameter int WIN_LO_CYC = ENTRY_MIN_CYC,
	parameter int WIN_HI_CYC = ENTRY_MAX_CYC
) (
	input  wire logic        CORE_CLK,
	input  wire logic        NRST,
	input  wire logic [11:0] ANGLE,
	swl_link_if.device       LINK,
	output logic             CMD_MODE,
	output logic [15:0]      USER_CTRL,
	output logic [15:0]      TEST_CTRL
);
	typedef enum logic [8:0] {
		L_IDLE   = 9'h001,
		L_CMD    = 9'h002,
		L_WDATA  = 9'h004,
		L_HOWAIT = 9'h008,
		L_TKO    = 9'h010,
		L_TX     = 9'h020,
		L_TXHO   = 9'h040,
		L_WSTOP  = 9'h080,
		L_SKIP   = 9'h100
	} swl_lstate_t;

	swl_lstate_t         state_ff, nxt_state;
	logic [4:0]          bits_ff, nxt_bits;
	logic [15:0]         sh_ff, nxt_sh, wword, rd_word;
	logic [7:0]          cmd_ff, nxt_cmd, cmd_new;
	logic [CW-1:0]       tmr_ff, nxt_tmr, per_ff, nxt_per;
	logic                mode_ff, nxt_mode;
	logic [15:0]         nvm_ff [NVM_WORDS];
	logic [15:0]         nxt_nvm [NVM_WORDS];
	logic [15:0]         uctl_ff, nxt_uctl, tctl_ff, nxt_tctl;
	logic [15:0]         sig_ff, nxt_sig;
	logic                oe_ff, nxt_oe, out_ff, nxt_out;
	logic [PW-1:0]       por_ff, nxt_por;
	logic                in_win, started;
	logic [SENT_CW-1:0]  tick_ff, nxt_tick, scnt_ff, nxt_scnt, elem_len;
	logic [2:0]          idx_ff, nxt_idx;
	logic [11:0]         ang_ff, nxt_ang;
	logic [3:0]          nib;
	logic                sent_lvl;
	logic                rx_rise, rx_fall, rx_to, rx_bv, rx_bval;
	logic [CW-1:0]       rx_per;

	swl_pulse_rx #(
		.TO_CYC (TO_CYC)
	) u_rx (
		.clk      (CORE_CLK),
		.nrst     (NRST),
		.line_raw (LINK.line),
		.rise     (rx_rise),
		.fall     (rx_fall),
		.timeout  (rx_to),
		.bit_vld  (rx_bv),
		.bit_val  (rx_bval),
		.period   (rx_per)
	);

	// Power-on timer; it saturates just past the entry slot, so late entry fails.
	always_comb begin
		nxt_por = (por_ff == PW'(WIN_HI_CYC + 1)) ? por_ff : por_ff + 1'b1;
		in_win  = (por_ff >= PW'(WIN_LO_CYC)) && (por_ff <= PW'(WIN_HI_CYC));
		started = por_ff >= PW'(ON_CYC);
	end

	// Angle frame generator: sync element, status nibble, three angle nibbles.
	always_comb begin
		unique case (idx_ff)
			3'h1:    nib = nvm_ff[0][3:0];
			3'h2:    nib = ang_ff[11:8];
			3'h3:    nib = ang_ff[7:4];
			default: nib = ang_ff[3:0];
		endcase
		elem_len = (idx_ff == '0) ? SENT_CW'(SENT_SYNC)
			: SENT_CW'(SENT_NIB_BASE) + SENT_CW'(nib);
		sent_lvl = scnt_ff >= SENT_CW'(SENT_LOW);
		nxt_tick = tick_ff + 1'b1;
		nxt_scnt = scnt_ff;
		nxt_idx  = idx_ff;
		nxt_ang  = ang_ff;
		if (tick_ff == SENT_CW'(SENT_TICK_CYC - 1)) begin
			nxt_tick = '0;
			nxt_scnt = scnt_ff + 1'b1;
			if (scnt_ff == elem_len - 1'b1) begin
				nxt_scnt = '0;
				nxt_idx  = idx_ff + 1'b1;
				if (idx_ff == 3'(SENT_ELEMS - 1)) begin
					nxt_idx = '0;
					nxt_ang = ANGLE;
				end
			end
		end
	end

	// Word returned by a read; reserved regions and addresses answer zero.
	always_comb begin
		rd_word = '0;
		if (cmd_region(cmd_ff) == RGN_NVM) begin
			rd_word = nvm_ff[cmd_addr(cmd_ff)];
		end else if (cmd_region(cmd_ff) == RGN_REG) begin
			if (cmd_addr(cmd_ff) == ADR_USER_CTRL) begin
				rd_word = uctl_ff;
			end else if (cmd_addr(cmd_ff) == ADR_TEST_CTRL) begin
				rd_word = tctl_ff;
			end else if (cmd_addr(cmd_ff) == ADR_SIGNATURE) begin
				rd_word = sig_ff;
			end
		end
	end

	// Link sequencer; the sensor end only ever reacts to the master.
	always_comb begin
		nxt_state = state_ff;
		nxt_bits  = bits_ff;
		nxt_sh    = sh_ff;
		nxt_cmd   = cmd_ff;
		nxt_tmr   = tmr_ff + 1'b1;
		nxt_per   = per_ff;
		nxt_mode  = mode_ff;
		nxt_nvm   = nvm_ff;
		nxt_uctl  = uctl_ff;
		nxt_tctl  = tctl_ff;
		nxt_sig   = sig_ff;
		cmd_new   = {sh_ff[6:0], rx_bval};
		wword     = {sh_ff[14:0], rx_bval};
		unique case (state_ff)
			L_IDLE: begin
				if (rx_rise) begin
					nxt_state = L_CMD;
					nxt_bits  = '0;
				end
			end
			L_CMD: begin
				if (rx_bv) begin
					nxt_sh   = wword;
					nxt_bits = bits_ff + 1'b1;
					if (bits_ff == 5'(CMD_BITS - 1)) begin
						nxt_cmd  = cmd_new;
						nxt_bits = '0;
						nxt_per  = rx_per;
						nxt_tmr  = '0;
						if (!cmd_new[RW_BIT]) begin
							nxt_state = L_WDATA;
						end else if (mode_ff) begin
							nxt_state = L_HOWAIT;
						end else begin
							nxt_state = L_SKIP;
						end
					end
				end
			end
			L_WDATA: begin
				if (rx_bv) begin
					nxt_sh   = wword;
					nxt_bits = bits_ff + 1'b1;
					if (bits_ff == 5'(WORD_BITS - 1)) begin
						nxt_state = L_IDLE;
						if (!mode_ff) begin
							if (cmd_ff == ENTRY_CMD && wword == sig_ff
								&& in_win) begin
								nxt_mode = 1'b1;
							end
						end else if (cmd_region(cmd_ff) == RGN_NVM) begin
							nxt_nvm[cmd_addr(cmd_ff)] = wword;
						end else if (cmd_region(cmd_ff) == RGN_REG) begin
							if (cmd_addr(cmd_ff) == ADR_USER_CTRL) begin
								nxt_uctl = wword;
							end else if (cmd_addr(cmd_ff) == ADR_TEST_CTRL) begin
								nxt_tctl = wword;
							end else if (cmd_addr(cmd_ff) == ADR_SIGNATURE) begin
								nxt_sig = wword;
							end
						end
					end
				end
			end
			L_HOWAIT: begin
				if (rx_fall) begin
					nxt_state = L_TKO;
				end
			end
			L_TKO: begin
				// Hold low past the master release, then start the first bit.
				if (tmr_ff == per_ff - (per_ff >> 2) + CW'(TKO_SLV_CYC)) begin
					nxt_state = L_TX;
					nxt_tmr   = '0;
					nxt_bits  = '0;
					nxt_sh    = rd_word;
				end
			end
			L_TX: begin
				if (tmr_ff == per_ff - 1'b1) begin
					nxt_tmr  = '0;
					nxt_sh   = {sh_ff[14:0], 1'b0};
					nxt_bits = bits_ff + 1'b1;
					if (bits_ff == 5'(WORD_BITS - 1)) begin
						nxt_state = L_TXHO;
					end
				end
			end
			L_TXHO: begin
				if (tmr_ff == per_ff - (per_ff >> 2)) begin
					nxt_state = L_WSTOP;
				end
			end
			L_WSTOP: begin
				if (rx_rise) begin
					nxt_state = L_IDLE;
				end
			end
			L_SKIP: begin
				nxt_state = L_SKIP;
			end
		endcase
		// Silence drops any receive phase; own transmit phases are timed.
		if (rx_to && !(state_ff inside {L_TKO, L_TX, L_TXHO})) begin
			nxt_state = L_IDLE;
		end
	end

	// Pin driver: frames in normal mode, slave phases in command mode.
	always_comb begin
		nxt_oe  = 1'b0;
		nxt_out = 1'b1;
		if (!mode_ff) begin
			nxt_oe  = started;
			nxt_out = sent_lvl;
		end else if (state_ff == L_TKO) begin
			nxt_oe  = 1'b1;
			nxt_out = 1'b0;
		end else if (state_ff == L_TX) begin
			nxt_oe  = 1'b1;
			nxt_out = tmr_ff < high_width(per_ff, sh_ff[15]);
		end else if (state_ff == L_TXHO) begin
			nxt_oe  = 1'b1;
			nxt_out = tmr_ff < (per_ff >> 2);
		end
	end

	// State registers; command mode leaves only through reset.
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			state_ff <= L_IDLE;
			bits_ff  <= '0;
			sh_ff    <= '0;
			cmd_ff   <= '0;
			tmr_ff   <= '0;
			per_ff   <= '0;
			mode_ff  <= 1'b0;
			nvm_ff   <= '{default: '0};
			uctl_ff  <= '0;
			tctl_ff  <= '0;
			sig_ff   <= SIG_INIT;
			oe_ff    <= 1'b0;
			out_ff   <= 1'b1;
			por_ff   <= '0;
			tick_ff  <= '0;
			scnt_ff  <= '0;
			idx_ff   <= '0;
			ang_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			bits_ff  <= nxt_bits;
			sh_ff    <= nxt_sh;
			cmd_ff   <= nxt_cmd;
			tmr_ff   <= nxt_tmr;
			per_ff   <= nxt_per;
			mode_ff  <= nxt_mode;
			nvm_ff   <= nxt_nvm;
			uctl_ff  <= nxt_uctl;
			tctl_ff  <= nxt_tctl;
			sig_ff   <= nxt_sig;
			oe_ff    <= nxt_oe;
			out_ff   <= nxt_out;
			por_ff   <= nxt_por;
			tick_ff  <= nxt_tick;
			scnt_ff  <= nxt_scnt;
			idx_ff   <= nxt_idx;
			ang_ff   <= nxt_ang;
		end
	end

	assign LINK.dev_oe  = oe_ff;
	assign LINK.dev_out = out_ff;
	assign CMD_MODE     = mode_ff;
	assign USER_CTRL    = uctl_ff;
	assign TEST_CTRL    = tctl_ff;
endmodule : swl_dev_end
`default_nettype wire

// ==== verilog/swl_pkg.sv ====
// Shared constants, field positions and helpers for the single-line link.
`default_nettype none
package swl_pkg;
	localparam int CLK_MHZ       = 20;
	localparam int CW            = 20;
	localparam int PW            = 20;
	localparam int TIMEOUT_US    = 250;
	localparam int TIMEOUT_CYC   = TIMEOUT_US * CLK_MHZ;
	localparam int ENTRY_MIN_MS  = 20;
	localparam int ENTRY_MAX_MS  = 30;
	localparam int ENTRY_MIN_CYC = ENTRY_MIN_MS * 1000 * CLK_MHZ;
	localparam int ENTRY_MAX_CYC = ENTRY_MAX_MS * 1000 * CLK_MHZ;
	localparam int STARTUP_US    = 1000;
	localparam int STARTUP_CYC   = STARTUP_US * CLK_MHZ;
	localparam int TKO_SLV_US    = 2;
	localparam int TKO_SLV_CYC   = TKO_SLV_US * CLK_MHZ;
	localparam int START_US      = 5;
	localparam int START_CYC     = START_US * CLK_MHZ;
	localparam int STOP_US       = 5;
	localparam int STOP_CYC      = STOP_US * CLK_MHZ;
	localparam int BIT_MIN_US    = 10;
	localparam int BIT_MAX_US    = 100;
	localparam int BIT_US        = 20;
	localparam int BIT_CYC       = BIT_US * CLK_MHZ;
	localparam int SENT_TICK_NS  = 3000;
	localparam int SENT_TICK_CYC = SENT_TICK_NS * CLK_MHZ / 1000;
	localparam int SENT_SYNC     = 56;
	localparam int SENT_NIB_BASE = 12;
	localparam int SENT_LOW      = 5;
	localparam int SENT_ELEMS    = 5;
	localparam int SENT_CW       = 6;
	localparam int CMD_BITS      = 8;
	localparam int WORD_BITS     = 16;
	localparam int NVM_WORDS     = 16;
	localparam int RGN_LSB       = 5;
	localparam int ADR_LSB       = 1;
	localparam int RW_BIT        = 0;
	localparam logic [7:0]  ENTRY_CMD     = 8'h94;
	// Arbitrary value; the real entry signature is not given.
	localparam logic [15:0] SIG_INIT      = 16'h5A3C;
	localparam logic [2:0]  RGN_NVM       = 3'h0;
	localparam logic [2:0]  RGN_REG       = 3'h4;
	localparam logic [3:0]  ADR_USER_CTRL = 4'h1;
	localparam logic [3:0]  ADR_TEST_CTRL = 4'h2;
	localparam logic [3:0]  ADR_SIGNATURE = 4'hA;

	// High time of one bit: three quarters for a one, a quarter for a zero.
	function automatic logic [CW-1:0] high_width(input logic [CW-1:0] per,
		input logic val);
		return val ? per - (per >> 2) : per >> 2;
	endfunction : high_width

	function automatic logic [2:0] cmd_region(input logic [7:0] c);
		return c[RGN_LSB +: 3];
	endfunction : cmd_region

	function automatic logic [3:0] cmd_addr(input logic [7:0] c);
		return c[ADR_LSB +: 4];
	endfunction : cmd_addr
endpackage : swl_pkg
`default_nettype wire

// ==== verilog/swl_link_if.sv ====
// Shared data line between the programming master and the sensor end.
`timescale 1ns/100ps
`default_nettype none
interface swl_link_if;
	logic host_out;
	logic host_oe;
	logic dev_out;
	logic dev_oe;
	logic line;

	// The master overdrives the sensor driver; a pull-up holds an idle line.
	assign line = host_oe ? host_out : (dev_oe ? dev_out : 1'b1);

	modport device (input line, output dev_out, output dev_oe);
	modport host (input line, output host_out, output host_oe);
endinterface : swl_link_if
`default_nettype wire

// ==== verilog/swl_pulse_rx.sv ====
// Line synchroniser, edge finder, time-out and pulse-width bit decoder.
`timescale 1ns/100ps
`default_nettype none
module swl_pulse_rx
	import swl_pkg::*;
#(
	parameter int TO_CYC = TIMEOUT_CYC
) (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          line_raw,
	output logic               rise,
	output logic               fall,
	output logic               timeout,
	output logic               bit_vld,
	output logic               bit_val,
	output logic [CW-1:0]      period
);
	logic          sync1_ff, sync2_ff, prev_ff, armed_ff, bv_ff, bval_ff;
	logic          nxt_armed, nxt_bv, nxt_bval;
	logic [CW-1:0] cnt_ff, hiw_ff, per_ff;
	logic [CW-1:0] nxt_cnt, nxt_hiw, nxt_per;

	// Edges and the silence detector look only at the second stage.
	always_comb begin
		rise      = sync2_ff & ~prev_ff;
		fall      = ~sync2_ff & prev_ff;
		timeout   = armed_ff && (cnt_ff == CW'(TO_CYC));
		nxt_cnt   = (cnt_ff == CW'(TO_CYC)) ? cnt_ff : cnt_ff + 1'b1;
		nxt_hiw   = fall ? cnt_ff : hiw_ff;
		nxt_armed = armed_ff;
		nxt_bv    = 1'b0;
		nxt_bval  = bval_ff;
		nxt_per   = per_ff;
		if (timeout) begin
			nxt_armed = 1'b0;
		end
		if (rise) begin
			// A bit ends at the next rise, so its whole period is known here.
			nxt_cnt   = '0;
			nxt_armed = 1'b1;
			nxt_bv    = armed_ff;
			nxt_bval  = {hiw_ff, 1'b0} > {1'b0, cnt_ff};
			// The count starts at zero after a rise, so one cycle is added.
			nxt_per   = armed_ff ? cnt_ff + 1'b1 : per_ff;
		end
	end

	// Registers; the first sync stage feeds only the second.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			prev_ff  <= 1'b1;
			armed_ff <= 1'b0;
			bv_ff    <= 1'b0;
			bval_ff  <= 1'b0;
			cnt_ff   <= '0;
			hiw_ff   <= '0;
			per_ff   <= '0;
		end else begin
			sync1_ff <= line_raw;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
			armed_ff <= nxt_armed;
			bv_ff    <= nxt_bv;
			bval_ff  <= nxt_bval;
			cnt_ff   <= nxt_cnt;
			hiw_ff   <= nxt_hiw;
			per_ff   <= nxt_per;
		end
	end

	assign bit_vld = bv_ff;
	assign bit_val = bval_ff;
	assign period  = per_ff;
endmodule : swl_pulse_rx
`default_nettype wire

// ==== verilog/swl_host_end.sv ====
// Programming master end: frames one write or read per start request.
`timescale 1ns/100ps
`default_nettype none
module swl_host_end
	import swl_pkg::*;
#(
	parameter int BIT_CYC_P = BIT_CYC,
	parameter int TO_CYC    = TIMEOUT_CYC
) (
	input  wire logic        CORE_CLK,
	input  wire logic        NRST,
	input  wire logic        START,
	input  wire logic [7:0]  CMD,
	input  wire logic [15:0] WDATA,
	swl_link_if.host         LINK,
	output logic             BUSY,
	output logic             DONE,
	output logic [15:0]      RDATA
);
	typedef enum logic [7:0] {
		H_IDLE  = 8'h01,
		H_GUARD = 8'h02,
		H_START = 8'h04,
		H_BITS  = 8'h08,
		H_HO    = 8'h10,
		H_RX    = 8'h20,
		H_TKO   = 8'h40,
		H_STOP  = 8'h80
	} swl_hstate_t;

	// Bit period must lie within the 10 to 100 us the line allows.
	localparam logic [CW-1:0] PER = CW'(BIT_CYC_P);
	localparam logic [CW-1:0] QTR = PER >> 2;

	swl_hstate_t   state_ff, nxt_state;
	logic [CW-1:0] tmr_ff, nxt_tmr;
	logic [4:0]    bits_ff, nxt_bits, rcnt_ff, nxt_rcnt;
	logic [23:0]   sh_ff, nxt_sh;
	logic [15:0]   rd_ff, nxt_rd, rdata_ff, nxt_rdata;
	logic          rw_ff, nxt_rw, oe_ff, nxt_oe, out_ff, nxt_out;
	logic          busy_ff, done_ff, nxt_done;
	logic          rx_fall, rx_to, rx_bv, rx_bval;

	swl_pulse_rx #(
		.TO_CYC (TO_CYC)
	) u_rx (
		.clk      (CORE_CLK),
		.nrst     (NRST),
		.line_raw (LINK.line),
		.rise     (),
		.fall     (rx_fall),
		.timeout  (rx_to),
		.bit_vld  (rx_bv),
		.bit_val  (rx_bval),
		.period   ()
	);

	// Transaction sequencer; the master alone starts every exchange.
	always_comb begin
		nxt_state = state_ff;
		nxt_tmr   = tmr_ff + 1'b1;
		nxt_bits  = bits_ff;
		nxt_rcnt  = rcnt_ff;
		nxt_sh    = sh_ff;
		nxt_rd    = rd_ff;
		nxt_rw    = rw_ff;
		nxt_rdata = rdata_ff;
		nxt_done  = 1'b0;
		nxt_oe    = 1'b1;
		nxt_out   = 1'b1;
		unique case (state_ff)
			H_IDLE: begin
				nxt_oe = 1'b0;
				if (START) begin
					nxt_state = H_GUARD;
					nxt_tmr   = '0;
					nxt_sh    = {CMD, WDATA};
					nxt_rw    = CMD[RW_BIT];
				end
			end
			H_GUARD: begin
				// Driven high past the time-out: resyncs and overdrives output.
				if (tmr_ff == CW'(TO_CYC)) begin
					nxt_state = H_START;
					nxt_tmr   = '0;
				end
			end
			H_START: begin
				nxt_out = 1'b0;
				if (tmr_ff == CW'(START_CYC - 1)) begin
					nxt_state = H_BITS;
					nxt_tmr   = '0;
					nxt_bits  = '0;
				end
			end
			H_BITS: begin
				// Writes, including the entry word and checksum, use this path.
				nxt_out = tmr_ff < high_width(PER, sh_ff[23]);
				if (tmr_ff == PER - 1'b1) begin
					nxt_tmr  = '0;
					nxt_sh   = {sh_ff[22:0], 1'b0};
					nxt_bits = bits_ff + 1'b1;
					if (rw_ff && bits_ff == 5'(CMD_BITS - 1)) begin
						nxt_state = H_HO;
					end else if (bits_ff == 5'(CMD_BITS + WORD_BITS - 1)) begin
						nxt_state = H_STOP;
					end
				end
			end
			H_HO: begin
				nxt_out = tmr_ff < QTR;
				if (tmr_ff == PER - QTR - 1'b1) begin
					nxt_state = H_RX;
					nxt_rcnt  = '0;
				end
			end
			H_RX: begin
				// The first decoded bit is the handover itself and is dropped.
				nxt_oe = 1'b0;
				if (rx_bv) begin
					nxt_rcnt = rcnt_ff + 1'b1;
					if (rcnt_ff != '0) begin
						nxt_rd = {rd_ff[14:0], rx_bval};
					end
				end
				if (rx_fall && rcnt_ff == 5'(WORD_BITS + 1)) begin
					nxt_state = H_TKO;
					nxt_tmr   = '0;
				end else if (rx_to) begin
					nxt_state = H_STOP;
					nxt_tmr   = '0;
				end
			end
			H_TKO: begin
				nxt_out = 1'b0;
				if (tmr_ff == (PER >> 1) - 1'b1) begin
					nxt_state = H_STOP;
					nxt_tmr   = '0;
				end
			end
			H_STOP: begin
				if (tmr_ff == CW'(STOP_CYC - 1)) begin
					nxt_state = H_IDLE;
					nxt_done  = 1'b1;
					nxt_rdata = rd_ff;
				end
			end
		endcase
	end

	// Registers; all ports come straight from here.
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			state_ff <= H_IDLE;
			tmr_ff   <= '0;
			bits_ff  <= '0;
			rcnt_ff  <= '0;
			sh_ff    <= '0;
			rd_ff    <= '0;
			rw_ff    <= 1'b0;
			rdata_ff <= '0;
			done_ff  <= 1'b0;
			busy_ff  <= 1'b0;
			oe_ff    <= 1'b0;
			out_ff   <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			tmr_ff   <= nxt_tmr;
			bits_ff  <= nxt_bits;
			rcnt_ff  <= nxt_rcnt;
			sh_ff    <= nxt_sh;
			rd_ff    <= nxt_rd;
			rw_ff    <= nxt_rw;
			rdata_ff <= nxt_rdata;
			done_ff  <= nxt_done;
			busy_ff  <= nxt_state != H_IDLE;
			oe_ff    <= nxt_oe;
			out_ff   <= nxt_out;
		end
	end

	assign LINK.host_oe  = oe_ff;
	assign LINK.host_out = out_ff;
	assign BUSY          = busy_ff;
	assign DONE          = done_ff;
	assign RDATA         = rdata_ff;
endmodule : swl_host_end
`default_nettype wire

// ==== dv/swl_link_checker.sv ====
// Concurrent checks on the shared programming line between both ends.
`timescale 1ns/100ps
`default_nettype none
module swl_link_checker #(
	parameter int TO_CYC = 200
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic host_out,
	input wire logic host_oe,
	input wire logic dev_out,
	input wire logic dev_oe,
	input wire logic line,
	input wire logic CMD_MODE,
	input wire logic DONE
);
	logic [15:0] quiet_ff;
	logic [15:0] nxt_quiet;
	logic        line_ff;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!NRST);

	// Cycles since the last rise on the line; saturates so it never wraps.
	always_comb begin
		nxt_quiet = quiet_ff;
		if (line && !line_ff) begin
			nxt_quiet = 16'h0000;
		end else if (quiet_ff != 16'hFFFF) begin
			nxt_quiet = quiet_ff + 16'h0001;
		end
	end

	// Registered copy of the line and of the silence count.
	always_ff @(posedge CORE_CLK) begin
		line_ff  <= line;
		quiet_ff <= NRST ? nxt_quiet : 16'h0000;
	end

	// The device lets go of the line after its handover low.
	sequence s_slave_hand;
		$fell(dev_oe) && $past(CMD_MODE, 16);
	endsequence
	sequence s_host_low;
		host_oe && !host_out;
	endsequence

	a_reset_quiet: assert property ($rose(NRST) |->
		!dev_oe && !host_oe && !CMD_MODE)
		else $error("ends drive the line straight after reset");
	a_cmd_sticky: assert property (CMD_MODE |=> CMD_MODE)
		else $error("command mode left without reset");
	a_high_min: assert property (host_oe && $rose(host_out) |=>
		host_out [*8])
		else $error("host high pulse too short");
	a_low_min: assert property (host_oe && $fell(host_out) |=>
		(!host_out || !host_oe) [*8])
		else $error("host low phase too short");
	a_idle_quiet: assert property (CMD_MODE && quiet_ff > TO_CYC + 8
		|-> !dev_oe)
		else $error("device drives after the silence time-out");
	a_done_stop: assert property (DONE |-> host_oe && host_out
		&& $past(host_out, 8))
		else $error("transaction ended without a stop high");
	a_slave_takeover: assert property ($rose(dev_oe) && CMD_MODE
		|-> !dev_out && !line)
		else $error("device took the line without a handover low");
	a_slave_release: assert property (s_slave_hand |->
		!$past(dev_out))
		else $error("device released the line from high");
	a_master_takeover: assert property (s_slave_hand |->
		##[0:40] s_host_low)
		else $error("host did not take the line back low");
endmodule : swl_link_checker
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench: the host end programs the sensor end over one line.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import swl_pkg::*;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        hnrst = 1'b0;
	logic [11:0] angle = 12'h5A5;
	logic        start = 1'b0;
	logic [7:0]  cmd = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic        busy;
	logic        done;
	logic        cmd_mode;
	logic [15:0] rdata;
	logic [15:0] uctl;
	logic [15:0] tctl;
	int          err_count = 0;
	int          checks_done = 0;

	swl_link_if link ();

	// Half period of the 20 MHz core clock.
	always #25 clk = ~clk;

	// Short counts keep the run brief; the host has its own reset.
	swl_dev_end #(.TO_CYC(200), .ON_CYC(50), .WIN_LO_CYC(3000))
		u_swl_dev_end (.CORE_CLK(clk), .NRST(nrst),
		.ANGLE(angle), .LINK(link.device), .CMD_MODE(cmd_mode),
		.USER_CTRL(uctl), .TEST_CTRL(tctl));
	swl_host_end #(.BIT_CYC_P(40), .TO_CYC(200)) u_swl_host_end (
		.CORE_CLK(clk), .NRST(hnrst), .START(start), .CMD(cmd),
		.WDATA(wdata), .LINK(link.host), .BUSY(busy), .DONE(done),
		.RDATA(rdata));
	// The checker's default time-out already matches the short device one.
	swl_link_checker u_swl_link_checker (.CORE_CLK(clk),
		.NRST(nrst), .host_out(link.host_out), .host_oe(link.host_oe),
		.dev_out(link.dev_out), .dev_oe(link.dev_oe), .line(link.line),
		.CMD_MODE(cmd_mode), .DONE(done));

	task automatic chk(input string nm, input logic [15:0] exp,
		input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One host transaction; returns in the cycle that shows the end pulse.
	task automatic xfer(input logic [7:0] c, input logic [15:0] w);
		int n;
		n = 0;
		start <= 1'b1;
		cmd <= c;
		wdata <= w;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		chk("busy", 16'h0001, {15'h0000, busy});
		while (done !== 1'b1 && n < 6000) begin
			@(posedge clk);
			n++;
		end
		chk("done", 16'h0001, {15'h0000, done});
		chk("busy_end", 16'h0000, {15'h0000, busy});
	endtask : xfer

	task automatic t_reset;
		chk("cmd_mode", 16'h0000, {15'h0000, cmd_mode});
		chk("user_ctrl", 16'h0000, uctl);
		chk("test_ctrl", 16'h0000, tctl);
		chk("busy", 16'h0000, {15'h0000, busy});
	endtask : t_reset

	// Angle frames pull the line low while the host stays off it.
	task automatic t_frames;
		int n;
		n = 0;
		while (!(link.line === 1'b0 && link.host_oe === 1'b0) && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		chk("frame_low", 16'h0000, {15'h0000, link.line});
	endtask : t_frames

	// An entry before the slot opens, a plain write, a wrong code and a
	// wrong signature all leave the sensor in normal mode.
	task automatic t_bad_entry;
		xfer(ENTRY_CMD, SIG_INIT);
		chk("early_entry", 16'h0000, {15'h0000, cmd_mode});
		xfer(8'h82, 16'h1111);
		xfer(8'h96, SIG_INIT);
		xfer(ENTRY_CMD, ~SIG_INIT);
		chk("cmd_mode", 16'h0000, {15'h0000, cmd_mode});
		chk("user_ctrl", 16'h0000, uctl);
	endtask : t_bad_entry

	task automatic t_entry;
		xfer(ENTRY_CMD, SIG_INIT);
		repeat (10) @(posedge clk);
		chk("cmd_mode", 16'h0001, {15'h0000, cmd_mode});
	endtask : t_entry

	// Write then read back each place; reserved reads come back as zero.
	task automatic t_regs;
		logic [7:0]  cs [3] = '{8'h82, 8'h84, 8'h06};
		logic [15:0] vs [3] = '{16'h1234, 16'hBEEF, 16'hA55A};
		for (int i = 0; i < 3; i++) begin
			xfer(cs[i], vs[i]);
			xfer(cs[i] | 8'h01, 16'h0000);
			chk("rdata", vs[i], rdata);
		end
		chk("user_ctrl", 16'h1234, uctl);
		chk("test_ctrl", 16'hBEEF, tctl);
		xfer(8'h23, 16'h0000);
		chk("reserved", 16'h0000, rdata);
		xfer(8'h95, 16'h0000);
		chk("signature", SIG_INIT, rdata);
	endtask : t_regs

	// The host is knocked out mid write; the device must time out.
	task automatic t_abort;
		start <= 1'b1;
		cmd <= 8'h82;
		wdata <= 16'hFFFF;
		@(posedge clk);
		start <= 1'b0;
		repeat (700) @(posedge clk);
		hnrst <= 1'b0;
		repeat (3) @(posedge clk);
		hnrst <= 1'b1;
		repeat (2) @(posedge clk);
		xfer(8'h84, 16'h0F0F);
		chk("user_ctrl", 16'h1234, uctl);
		chk("test_ctrl", 16'h0F0F, tctl);
		chk("cmd_mode", 16'h0001, {15'h0000, cmd_mode});
	endtask : t_abort

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	// Main sequence after a ten cycle reset.
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		hnrst <= 1'b1;
		@(posedge clk);
		t_reset();
		t_frames();
		t_bad_entry();
		t_entry();
		t_regs();
		t_abort();
		final_report();
	end

	// The whole run needs some 20000 cycles; this cuts a hang short.
	initial begin
		repeat (80000) @(posedge clk);
		err_count++;
		$display("[ERR] watchdog expected end seen hang");
		final_report();
	end
endmodule : tb
`default_nettype wire
